/* File: verification/ext_periph_model.sv */
// External peripheral model on the aux strobe pins and port 2 pins
`timescale 1ns/1ns
module ext_periph_model (
  input wire logic [3:0] aux_pin,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe_n,
  input wire logic [7:0] drive_val,
  output logic [3:0] aux_level,
  output logic [7:0] p2_level
);
  // ****************************************
  // Pin levels
  // ****************************************
  // Aux pins are always driven by the device, so the wire is the drive
  assign aux_level = aux_pin;
  // Released port 2 bits carry the peripheral's byte, never a stale copy
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p2_level[i] = p2_oe_n[i] ? drive_val[i] : p2_out[i];
    end
  end
endmodule

/* File: verification/tb_port_chip_select_and_latch.sv */
// Self-checking bench for the strobe and port 2 expansion block
`timescale 1ns/1ns
module tb_port_chip_select_and_latch;
  import port_cs_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SFR_WR = 1'b0, SFR_RD = 1'b0, XRD = 1'b0, XWR = 1'b0, rd_taken_ff = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, XWDATA = 8'h00, drv = 8'h5a;
  logic [15:0] XADDR = 16'h0000, seed = 16'h003e;
  logic [7:0] SFR_RDATA, XRDATA, P2_IN, P2_OUT, P2_OE_N;
  logic [3:0] AUX_IN, AUX_OUT;
  logic SFR_HIT, XRDATA_VALID;
  logic [8:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;

  port_chip_select_and_latch port_chip_select_and_latch_i (.CLK(CLK), .RST_N(RST_N),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .XADDR(XADDR), .XRD(XRD), .XWR(XWR),
    .XWDATA(XWDATA), .XRDATA(XRDATA), .XRDATA_VALID(XRDATA_VALID), .AUX_IN(AUX_IN),
    .AUX_OUT(AUX_OUT), .P2_IN(P2_IN), .P2_OUT(P2_OUT), .P2_OE_N(P2_OE_N));
  ext_periph_model ext_periph_model_i (.aux_pin(AUX_OUT), .p2_out(P2_OUT), .p2_oe_n(P2_OE_N),
    .drive_val(drv), .aux_level(AUX_IN), .p2_level(P2_IN));

  initial begin
    forever #50 CLK = ~CLK;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [15:0] mask(input int l);
    case (l)
      0: return 16'hffff;
      1: return 16'hfffe;
      2: return 16'hfffc;
      default: return 16'hff00;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic step();
    @(posedge CLK);
    #2;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    step();
    SFR_WR = 1'b0;
    step();
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [8:0] want);
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    exp_q.push_back(want);
    step();
    SFR_RD = 1'b0;
    step();
  endtask
  // One-cycle phase; pins sampled in the lag cycle and one cycle after the end
  task automatic xacc(input logic wr, input logic [15:0] a, input logic [7:0] d,
      output logic [3:0] on, output logic [3:0] off);
    XADDR = a;
    XWDATA = d;
    XWR = wr;
    XRD = ~wr;
    step();
    on = AUX_OUT;
    XWR = 1'b0;
    XRD = 1'b0;
    step();
    off = AUX_OUT;
  endtask
  task automatic final_report();
    if (exp_q.size() != 0) begin
      check("pending results", 16'(exp_q.size()), 16'h0000);
    end
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge CLK) begin
    rd_taken_ff <= SFR_RD;
  end
  always @(negedge CLK) begin
    if (rd_taken_ff || XRDATA_VALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected result", 16'h0001, 16'h0000);
      end else if (rd_taken_ff) begin
        check("reg read", {7'h00, SFR_HIT, SFR_RDATA}, {7'h00, exp_q.pop_front()});
      end else begin
        check("buffer read", {7'h00, XRDATA_VALID, XRDATA}, {7'h00, exp_q.pop_front()});
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] b, a, ea;
    logic [3:0] on, off, want;
    logic [7:0] ctl;
    logic p;
    repeat (16) @(posedge CLK);
    #2;
    RST_N = 1'b1;
    check("aux reset", AUX_OUT, 4'hf);
    check("p2 reset", {P2_OE_N, P2_OUT}, 16'h00ff);
    sfr_rd(STROBE_CTRL_LOW_ADDR, 9'h100);
    sfr_rd(P2_EXPAND_CTRL_ADDR, 9'h100);
    sfr_rd(AUX_PORT_DATA_ADDR, 9'h10f);
    sfr_rd(8'h80, 9'h000);
    $display("test reset done");
    // Every pin, strobe function and length; random base and polarity
    for (int i = 0; i < 4; i++) begin
      for (int f = 1; f < 4; f++) begin
        for (int l = 0; l < 4; l++) begin
          b = rnd();
          p = b[0];
          ctl = 8'({f[1:0], l[1:0]}) << (4 * (i % 2));
          sfr_wr(i < 2 ? STROBE_CTRL_LOW_ADDR : STROBE_CTRL_HIGH_ADDR, ctl);
          sfr_wr(i < 2 ? STROBE_CTRL_HIGH_ADDR : STROBE_CTRL_LOW_ADDR, 8'h00);
          sfr_wr(STROBE_BASE_HIGH_ADDR[i], b[15:8]);
          sfr_wr(STROBE_BASE_LOW_ADDR[i], b[7:0]);
          sfr_wr(P2_EXPAND_CTRL_ADDR, 8'({p, 4'h0}) << i);
          sfr_rd(i < 2 ? STROBE_CTRL_LOW_ADDR : STROBE_CTRL_HIGH_ADDR, {1'b1, ctl});
          sfr_rd(STROBE_BASE_HIGH_ADDR[i], {1'b1, b[15:8]});
          for (int k = 0; k < 4; k++) begin
            a = k > 1 ? b ^ 16'h8000 : b ^ (rnd() & ~mask(l));
            xacc(k[0], a, 8'h00, on, off);
            want = 4'hf;
            want[i] = (k < 2 && (k[0] ? f[1] : f[0])) ? p : ~p;
            check("strobe on", on, want);
            want[i] = ~p;
            check("strobe off", off, want);
          end
        end
      end
    end
    $display("test strobes done");
    sfr_wr(STROBE_CTRL_HIGH_ADDR, 8'h00);
    sfr_wr(STROBE_CTRL_LOW_ADDR, 8'h0a);
    sfr_wr(P2_EXPAND_CTRL_ADDR, 8'h00);
    sfr_wr(AUX_PORT_DATA_ADDR, 8'hf0);
    check("gpio beside strobe", AUX_OUT, 4'h1);
    sfr_rd(AUX_PORT_DATA_ADDR, 9'h101);
    sfr_wr(STROBE_CTRL_LOW_ADDR, 8'h00);
    check("gpio restored", AUX_OUT, 4'h1);
    $display("test gpio done");
    ea = rnd();
    sfr_wr(P2_EA_LOW_ADDR, ea[7:0]);
    sfr_wr(P2_EA_HIGH_ADDR, ea[15:8]);
    sfr_rd(P2_EA_HIGH_ADDR, {1'b1, ea[15:8]});
    sfr_rd(P2_EA_LOW_ADDR, {1'b1, ea[7:0]});
    sfr_wr(P2_EXPAND_CTRL_ADDR, 8'h02);
    xacc(1'b1, ea, 8'h55, on, off);
    check("latch drive", {P2_OE_N, P2_OUT}, 16'h0055);
    xacc(1'b1, ea ^ 16'h0001, 8'h33, on, off);
    sfr_wr(PORT2_DATA_ADDR, 8'hc3);
    check("latch held", {P2_OE_N, P2_OUT}, 16'h0055);
    sfr_wr(P2_EXPAND_CTRL_ADDR, 8'h01);
    b = rnd();
    drv = b[7:0];
    exp_q.push_back({1'b1, drv});
    xacc(1'b0, ea, 8'h00, on, off);
    xacc(1'b0, ea ^ 16'h0100, 8'h00, on, off);
    sfr_wr(PORT2_DATA_ADDR, 8'h3c);
    check("buffer pins", {P2_OE_N, P2_OUT}, 16'hff55);
    sfr_wr(P2_EXPAND_CTRL_ADDR, 8'hff);
    sfr_rd(P2_EXPAND_CTRL_ADDR, 9'h1f3);
    check("standard mode", {P2_OE_N, P2_OUT}, 16'h003c);
    $display("test port2 done");
    final_report();
  end
endmodule

/* File: verilog/addr_compare.sv */
// Masked 16-bit address comparator
`timescale 1ns/1ns
module addr_compare (
  input wire logic [15:0] base,
  input wire logic [15:0] addr,
  input wire port_cs_pkg::cmp_len_t len,
  output logic match
);
  import port_cs_pkg::*;

  logic [15:0] mask;

  always_comb begin
    unique case (len)
      CMP_ALL16: mask = MASK_ALL16;
      CMP_UPPER15: mask = MASK_UPPER15;
      CMP_UPPER14: mask = MASK_UPPER14;
      CMP_UPPER8: mask = MASK_UPPER8;
    endcase
    match = ((base ^ addr) & mask) == 16'h0000;
  end

endmodule

/* File: verilog/port_chip_select_and_latch.sv */
// Chip-select strobes on the aux port and port 2 buffer and latch expansion
`timescale 1ns/1ns
module port_chip_select_and_latch (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  input wire logic [15:0] XADDR,
  input wire logic XRD,
  input wire logic XWR,
  input wire logic [7:0] XWDATA,
  output logic [7:0] XRDATA,
  output logic XRDATA_VALID,
  input wire logic [port_cs_pkg::AUX_PINS-1:0] AUX_IN,
  output logic [port_cs_pkg::AUX_PINS-1:0] AUX_OUT,
  input wire logic [7:0] P2_IN,
  output logic [7:0] P2_OUT,
  output logic [7:0] P2_OE_N
);
  import port_cs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] p2_ctrl;
    logic [7:0] ctrl_low;
    logic [7:0] ctrl_high;
    logic [3:0] aux_data;
    logic [3:0][15:0] base;
    logic [15:0] p2_ea;
    logic [7:0] p2_data;
    logic [7:0] p2_latch;
    logic [3:0] aux_out;
    logic [7:0] p2_out;
    logic [7:0] p2_oe_n;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [7:0] xrdata;
    logic xrdata_valid;
  } state_t;

  localparam state_t ST_RESET = '{
    p2_ctrl: P2_EXPAND_RST,
    ctrl_low: STROBE_CTRL_RST,
    ctrl_high: STROBE_CTRL_RST,
    aux_data: AUX_DATA_RST,
    base: {ADDR_RST, ADDR_RST, ADDR_RST, ADDR_RST},
    p2_ea: ADDR_RST,
    p2_data: PORT2_DATA_RST,
    p2_latch: PORT2_DATA_RST,
    aux_out: AUX_DATA_RST,
    p2_out: PORT2_DATA_RST,
    p2_oe_n: BYTE_ZERO,
    sfr_rdata: BYTE_ZERO,
    sfr_hit: 1'b0,
    xrdata: BYTE_ZERO,
    xrdata_valid: 1'b0
  };

  state_t st_ff;
  state_t nxt_st;

  // ****************************************
  // Pin decode
  // ****************************************
  logic [15:0] ctrl_all;
  pin_fun_t [3:0] pin_fun;
  cmp_len_t [3:0] pin_len;
  logic [3:0] gp;
  logic [3:0] match;
  logic [3:0] cs_hit;
  logic [3:0] pol;
  p2_mode_t p2_mode;
  logic p2_match;
  logic latch_hit;
  logic buf_hit;
  logic p2_wr;
  logic aux_wr;

  assign ctrl_all = {st_ff.ctrl_high, st_ff.ctrl_low};
  assign pol = st_ff.p2_ctrl[POL_POS +: AUX_PINS];
  assign p2_mode = p2_mode_t'(st_ff.p2_ctrl[P2_MODE_POS +: 2]);
  assign p2_wr = SFR_WR && (SFR_ADDR == PORT2_DATA_ADDR);
  assign aux_wr = SFR_WR && (SFR_ADDR == AUX_PORT_DATA_ADDR);

  genvar gi;
  generate
    for (gi = 0; gi < AUX_PINS; gi++) begin : g_pin
      // Pins 1:0 sit in the low control byte, pins 3:2 in the high one
      assign pin_fun[gi] = pin_fun_t'(ctrl_all[gi*PIN_FIELD_W+FUN_POS +: 2]);
      assign pin_len[gi] = cmp_len_t'(ctrl_all[gi*PIN_FIELD_W+LEN_POS +: 2]);
      assign gp[gi] = (pin_fun[gi] == PIN_GPIO);

      addr_compare u_cmp (
        .base(st_ff.base[gi]),
        .addr(XADDR),
        .len(pin_len[gi]),
        .match(match[gi])
      );

      // Read bit and write bit of the function code map straight onto the phases
      assign cs_hit[gi] = match[gi] && ((pin_fun[gi][0] && XRD) || (pin_fun[gi][1] && XWR));
    end
  endgenerate

  addr_compare u_p2_cmp (
    .base(st_ff.p2_ea),
    .addr(XADDR),
    .len(CMP_ALL16),
    .match(p2_match)
  );

  assign latch_hit = (p2_mode == P2_OUT_LATCH) && XWR && p2_match;
  assign buf_hit = (p2_mode == P2_IN_BUFFER) && XRD && p2_match;

  // ****************************************
  // Register read mux
  // ****************************************
  function automatic logic [8:0] sfr_read(input logic [7:0] a, input state_t s,
                                          input logic [3:0] pins);
    logic [8:0] r;
    r = {1'b1, BYTE_ZERO};
    unique case (a)
      P2_EXPAND_CTRL_ADDR: r[7:0] = s.p2_ctrl;
      STROBE_CTRL_LOW_ADDR: r[7:0] = s.ctrl_low;
      STROBE_CTRL_HIGH_ADDR: r[7:0] = s.ctrl_high;
      AUX_PORT_DATA_ADDR: r[7:0] = {4'h0, pins};
      PORT2_DATA_ADDR: r[7:0] = s.p2_data;
      P2_EA_LOW_ADDR: r[7:0] = s.p2_ea[7:0];
      P2_EA_HIGH_ADDR: r[7:0] = s.p2_ea[15:8];
      default: r[8] = 1'b0;
    endcase
    for (int i = 0; i < AUX_PINS; i++) begin
      if (a == STROBE_BASE_LOW_ADDR[i]) begin
        r = {1'b1, s.base[i][7:0]};
      end
      if (a == STROBE_BASE_HIGH_ADDR[i]) begin
        r = {1'b1, s.base[i][15:8]};
      end
    end
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sfr_hit = 1'b0;
    nxt_st.sfr_rdata = BYTE_ZERO;
    if (SFR_RD) begin
      // Aux reads show pin levels, upper bits read as zero
      {nxt_st.sfr_hit, nxt_st.sfr_rdata} = sfr_read(SFR_ADDR, st_ff, AUX_IN);
    end
    if (SFR_WR) begin
      unique case (SFR_ADDR)
        P2_EXPAND_CTRL_ADDR: nxt_st.p2_ctrl = SFR_WDATA & P2_EXPAND_WMASK;
        STROBE_CTRL_LOW_ADDR: nxt_st.ctrl_low = SFR_WDATA;
        STROBE_CTRL_HIGH_ADDR: nxt_st.ctrl_high = SFR_WDATA;
        PORT2_DATA_ADDR: nxt_st.p2_data = SFR_WDATA;
        P2_EA_LOW_ADDR: nxt_st.p2_ea[7:0] = SFR_WDATA;
        P2_EA_HIGH_ADDR: nxt_st.p2_ea[15:8] = SFR_WDATA;
        default: nxt_st.p2_data = st_ff.p2_data;
      endcase
      for (int i = 0; i < AUX_PINS; i++) begin
        if (SFR_ADDR == STROBE_BASE_LOW_ADDR[i]) begin
          nxt_st.base[i][7:0] = SFR_WDATA;
        end
        if (SFR_ADDR == STROBE_BASE_HIGH_ADDR[i]) begin
          nxt_st.base[i][15:8] = SFR_WDATA;
        end
        // Strobe pins keep their stored bit so a later switch back is glitch free
        if (aux_wr && gp[i]) begin
          nxt_st.aux_data[i] = SFR_WDATA[i];
        end
      end
    end
    for (int i = 0; i < AUX_PINS; i++) begin
      if (gp[i]) begin
        nxt_st.aux_out[i] = st_ff.aux_data[i];
      end else begin
        // One cycle behind the phase, since outputs are registered
        nxt_st.aux_out[i] = cs_hit[i] ? pol[i] : ~pol[i];
      end
    end
    if (latch_hit) begin
      nxt_st.p2_latch = XWDATA;
    end
    nxt_st.xrdata_valid = buf_hit;
    if (buf_hit) begin
      nxt_st.xrdata = P2_IN;
    end
    unique case (p2_mode)
      P2_IN_BUFFER: begin
        nxt_st.p2_oe_n = BYTE_ONES;
        nxt_st.p2_out = st_ff.p2_latch;
      end
      P2_OUT_LATCH: begin
        nxt_st.p2_oe_n = BYTE_ZERO;
        nxt_st.p2_out = st_ff.p2_latch;
      end
      default: begin
        // Undefined code behaves as the standard port
        nxt_st.p2_oe_n = BYTE_ZERO;
        nxt_st.p2_out = (XRD || XWR) ? XADDR[15:8] : st_ff.p2_data;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign SFR_RDATA = st_ff.sfr_rdata;
  assign SFR_HIT = st_ff.sfr_hit;
  assign XRDATA = st_ff.xrdata;
  assign XRDATA_VALID = st_ff.xrdata_valid;
  assign AUX_OUT = st_ff.aux_out;
  assign P2_OUT = st_ff.p2_out;
  assign P2_OE_N = st_ff.p2_oe_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  generate
    for (gi = 0; gi < AUX_PINS; gi++) begin : g_chk
      a_strobe_active_level: assert property (
        $past(cs_hit[gi]) && $past(!gp[gi]) |-> AUX_OUT[gi] == $past(pol[gi]))
        else $error("strobe pin not at its active level");
      a_strobe_idle_level: assert property (
        $past(!gp[gi]) && $past(!cs_hit[gi]) |-> AUX_OUT[gi] == !$past(pol[gi]))
        else $error("strobe pin active outside a matching access");
      a_gpio_drive_bit: assert property (
        (aux_wr && gp[gi]) ##1 (gp[gi] && !aux_wr) |=> AUX_OUT[gi] == $past(SFR_WDATA[gi], 2))
        else $error("plain port pin did not follow the written bit");
      a_strobe_data_keep: assert property (
        aux_wr && !gp[gi] |=> st_ff.aux_data[gi] == $past(st_ff.aux_data[gi]))
        else $error("strobe pin data bit changed by a port write");
      a_len_upper_byte: assert property (
        match[gi] && pin_len[gi] == CMP_UPPER8 |-> XADDR[15:8] == st_ff.base[gi][15:8])
        else $error("upper byte compare matched a wrong address");
      a_low_pol_default: assert property (
        !pol[gi] && !gp[gi] && !cs_hit[gi] ##1 (!pol[gi] && !gp[gi]) |-> AUX_OUT[gi])
        else $error("active low strobe idle level not high");
      a_rd_only_phase: assert property (
        pin_fun[gi] == PIN_RD_STROBE && XWR && !XRD |=> AUX_OUT[gi] == !$past(pol[gi]))
        else $error("read strobe pin pulsed on a write");
      a_wr_only_phase: assert property (
        pin_fun[gi] == PIN_WR_STROBE && XRD && !XWR |=> AUX_OUT[gi] == !$past(pol[gi]))
        else $error("write strobe pin pulsed on a read");
      a_rw_both_phases: assert property (
        pin_fun[gi] == PIN_RW_STROBE && match[gi] && (XRD || XWR) |=>
          AUX_OUT[gi] == $past(pol[gi]))
        else $error("read and write strobe missed an access");
      a_base_readback: assert property (
        SFR_RD && !SFR_WR && SFR_ADDR == STROBE_BASE_HIGH_ADDR[gi] |=>
          SFR_HIT && SFR_RDATA == $past(st_ff.base[gi][15:8]))
        else $error("strobe base high byte readback wrong");
      a_len_full_match: assert property (
        match[gi] && pin_len[gi] == CMP_ALL16 |-> XADDR == st_ff.base[gi])
        else $error("full compare matched a wrong address");
      a_len_four_window: assert property (
        match[gi] && pin_len[gi] == CMP_UPPER14 |-> XADDR[15:2] == st_ff.base[gi][15:2])
        else $error("fourteen bit compare matched outside its window");
    end
  endgenerate

  a_latch_capture_hold: assert property (
    latch_hit ##1 (p2_mode == P2_OUT_LATCH && !latch_hit) |=>
      P2_OUT == $past(XWDATA, 2) && P2_OE_N == BYTE_ZERO)
    else $error("port 2 latch did not drive the written byte");

  a_sw_write_no_pin: assert property (
    (p2_wr && !latch_hit && (p2_mode == P2_IN_BUFFER || p2_mode == P2_OUT_LATCH))
      ##1 (p2_mode == $past(p2_mode) && !latch_hit) |=> $stable(P2_OUT))
    else $error("software write to port 2 reached the pins");

  a_buffer_read_data: assert property (
    buf_hit |=> XRDATA_VALID && XRDATA == $past(P2_IN))
    else $error("buffer read did not return the pin levels");

  a_buffer_mode_float: assert property (
    $past(p2_mode) == P2_IN_BUFFER |-> P2_OE_N == BYTE_ONES)
    else $error("port 2 driven in input buffer mode");

  a_latch_mode_drive: assert property (
    $past(p2_mode) == P2_OUT_LATCH |-> P2_OE_N == BYTE_ZERO)
    else $error("port 2 released in output latch mode");

  a_undefined_standard: assert property (
    $past(p2_mode) == P2_UNDEFINED |-> P2_OE_N == BYTE_ZERO)
    else $error("undefined port 2 mode did not act as standard");

  a_expand_reserved: assert property (
    SFR_WR && SFR_ADDR == P2_EXPAND_CTRL_ADDR |=>
      st_ff.p2_ctrl[3:2] == 2'h0 && st_ff.p2_ctrl[7:4] == $past(SFR_WDATA[7:4]))
    else $error("expansion control write stored wrongly");

  a_buffer_no_valid: assert property (
    !buf_hit |=> !XRDATA_VALID)
    else $error("buffer read data flagged without a buffer read");

  a_p2_data_store: assert property (
    p2_wr |=> st_ff.p2_data == $past(SFR_WDATA))
    else $error("port 2 data register missed a write");

  a_aux_upper_zero: assert property (
    SFR_RD && !SFR_WR && SFR_ADDR == AUX_PORT_DATA_ADDR |=>
      SFR_HIT && SFR_RDATA[7:4] == 4'h0)
    else $error("reserved aux data bits read nonzero");

  a_ctrl_readback: assert property (
    SFR_RD && !SFR_WR && SFR_ADDR == STROBE_CTRL_LOW_ADDR |=>
      SFR_HIT && SFR_RDATA == $past(st_ff.ctrl_low))
    else $error("strobe control low readback wrong");

  a_ea_write_read: assert property (
    SFR_WR && SFR_ADDR == P2_EA_HIGH_ADDR ##1 !SFR_WR
      ##1 (SFR_RD && !SFR_WR && SFR_ADDR == P2_EA_HIGH_ADDR)
      |=> SFR_RDATA == $past(SFR_WDATA, 3))
    else $error("enable address high byte not stored");

  // ****************************************
  // Cover points
  // ****************************************
  c_write_strobe: cover property (cs_hit[0] && XWR ##1 AUX_OUT[0] == pol[0]);
  c_read_strobe: cover property (cs_hit[3] && XRD && pin_fun[3] == PIN_RD_STROBE);
  c_latch_write: cover property (latch_hit ##2 P2_OUT == $past(XWDATA, 2));
  c_buffer_read: cover property (buf_hit ##1 XRDATA_VALID);
  c_gpio_beside_strobe: cover property (aux_wr && !gp[0] && gp[1]);

endmodule

/* File: verilog/port_cs_pkg.sv */
// Constants, field layouts and encodings for the chip-select and port-2 expansion block
// How it works
// - Low strobe control register holds pin 1 function in bits 7:6 and pin 0 function in 3:2.
// - The same register holds pin 1 compare length in bits 5:4 and pin 0 length in 1:0.
// - Function 00 is plain port bit, 01 read strobe, 10 write strobe, 11 both.
// - Length 00 compares all 16 bits, 01 bits 15:1, 10 bits 15:2, 11 bits 15:8.
// - Each of the four strobe pins has a 16-bit base in a high and a low byte register.
// - Aux data bits 3:0 drive pins 3:0 only in plain port mode; bits 7:4 are reserved.
// - A write to the aux data register changes only bits whose pin is a plain port bit.
// - A write strobe pin pulses on every external write matching its base, 4 addresses at 14 bits.
// - Expansion control bits 7:4 set the strobe polarity of pins 3:0, 1 is active high.
// - With the polarity bit cleared the strobe is active low; set, it is active high.
// - Expansion control bits 1:0 pick standard, input buffer, output latch or undefined.
// - Port 2 buffer and latch modes use a 16-bit enable address in two byte registers.
// - In latch mode an external write to the enable address drives and holds the byte on port 2.
// - In buffer or latch mode a software write to port 2 data changes only the register.
package port_cs_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] P2_EXPAND_CTRL_ADDR = 8'hae;
  localparam logic [7:0] STROBE_CTRL_LOW_ADDR = 8'hc2;
  localparam logic [7:0] STROBE_CTRL_HIGH_ADDR = 8'hc3;
  localparam logic [7:0] AUX_PORT_DATA_ADDR = 8'hd8;
  localparam logic [7:0] PORT2_DATA_ADDR = 8'ha0;
  localparam logic [7:0] P2_EA_LOW_ADDR = 8'h9e;
  localparam logic [7:0] P2_EA_HIGH_ADDR = 8'h9f;
  localparam logic [3:0][7:0] STROBE_BASE_LOW_ADDR = {8'hb4, 8'hac, 8'h94, 8'h84};
  localparam logic [3:0][7:0] STROBE_BASE_HIGH_ADDR = {8'hb5, 8'had, 8'h95, 8'h85};

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] P2_EXPAND_RST = 8'h00;
  localparam logic [7:0] STROBE_CTRL_RST = 8'h00;
  localparam logic [3:0] AUX_DATA_RST = 4'hf;
  localparam logic [7:0] PORT2_DATA_RST = 8'hff;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] P2_EXPAND_WMASK = 8'hf3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int AUX_PINS = 4;
  localparam int PIN_FIELD_W = 4;
  localparam int FUN_POS = 2;
  localparam int LEN_POS = 0;
  localparam int POL_POS = 4;
  localparam int P2_MODE_POS = 0;

  // ****************************************
  // Compare masks
  // ****************************************
  localparam logic [15:0] MASK_ALL16 = 16'hffff;
  localparam logic [15:0] MASK_UPPER15 = 16'hfffe;
  localparam logic [15:0] MASK_UPPER14 = 16'hfffc;
  localparam logic [15:0] MASK_UPPER8 = 16'hff00;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    PIN_GPIO = 2'h0,
    PIN_RD_STROBE = 2'h1,
    PIN_WR_STROBE = 2'h2,
    PIN_RW_STROBE = 2'h3
  } pin_fun_t;

  typedef enum logic [1:0] {
    CMP_ALL16 = 2'h0,
    CMP_UPPER15 = 2'h1,
    CMP_UPPER14 = 2'h2,
    CMP_UPPER8 = 2'h3
  } cmp_len_t;

  typedef enum logic [1:0] {
    P2_STANDARD = 2'h0,
    P2_IN_BUFFER = 2'h1,
    P2_OUT_LATCH = 2'h2,
    P2_UNDEFINED = 2'h3
  } p2_mode_t;

endpackage
